// ==== dsc_pkg.sv ====
package dsc_pkg;

    // host port widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 2;

    // clock of this block
    localparam int CLK_PERIOD_NS = 100;

    // coincident strobe low time for a serial-part hard reset
    localparam int HARD_RESET_MIN_NS = 150;
    localparam int HARD_RESET_CYCLES =
        (HARD_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // longest serial clock phase; no edge for longer means halted
    localparam int SERIAL_PHASE_MAX_NS = 2000;
    localparam int SERIAL_HALT_CYCLES =
        SERIAL_PHASE_MAX_NS / CLK_PERIOD_NS + 1;

    // end-of-transfer qualifying width
    localparam int EOP_MIN_NS = 70;
    localparam int EOP_CYCLES =
        (EOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // arbitration window after busy goes false
    localparam int ARB_MIN_NS = 1200;
    localparam int ARB_MAX_NS = 2400;
    localparam int ARB_START_CYCLES =
        (ARB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ARB_LATEST_CYCLES = ARB_MAX_NS / CLK_PERIOD_NS;

    // bus release limits; the block releases one cycle after the cause
    localparam int SEL_CLEAR_MAX_NS = 600;
    localparam int SEL_CLEAR_CYCLES = SEL_CLEAR_MAX_NS / CLK_PERIOD_NS;
    localparam int BSY_CLEAR_MAX_NS = 1100;
    localparam int BSY_CLEAR_CYCLES = BSY_CLEAR_MAX_NS / CLK_PERIOD_NS;
    localparam int RELEASE_CYCLES = 1;

    // counter widths
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] HALT_LIMIT = CNT_W'(SERIAL_HALT_CYCLES);
    localparam logic [CNT_W-1:0] ARB_LIMIT = CNT_W'(ARB_START_CYCLES - 1);

    // serial-part register reset values (index = address)
    localparam logic [DATA_W-1:0] SER_REG0_RST = 8'h00;
    localparam logic [DATA_W-1:0] SER_REG1_RST = 8'h00;
    localparam logic [DATA_W-1:0] SER_REG2_RST = 8'h00;
    localparam logic [DATA_W-1:0] SER_REG3_RST = 8'h00;
    localparam int SER_REG_NUM = 4;

    // scsi-part registers, cleared by scsi reset
    localparam logic [ADDR_W-1:0] SCSI_CTRL_OFS = 2'h0;
    localparam int SCSI_ARB_EN_BIT = 0;
    localparam logic [DATA_W-1:0] SCSI_REG_RST = 8'h00;

    typedef enum logic [1:0] {
        DSC_ARB_IDLE,
        DSC_ARB_WAIT,
        DSC_ARB_OWN
    } dsc_arb_state_t;

endpackage

// ==== dsc_hold_det.sv ====
// pulses once when cond has stood for HOLD consecutive cycles
module dsc_hold_det
    import dsc_pkg::*;
#(
    parameter int HOLD = 1
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic cond,
    output logic      hit
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    wire              reached = (cnt == CNT_W'(HOLD - 1));

    // saturate after the hit so a long hold gives one pulse only
    assign next_cnt = !cond ? '0 :
                      (cnt == CNT_W'(HOLD)) ? cnt : cnt + CNT_W'(1);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign hit = cond && reached;

endmodule

// ==== dsc_sleep_ctrl.sv ====
module dsc_sleep_ctrl
    import dsc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              serial_clk,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic              serial_part_select_n,
    input  wire logic              scsi_part_select_n,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    input  wire logic              soft_reset,
    input  wire logic              scsi_reset_n,
    input  wire logic              transfer_end_n,
    input  wire logic              dma_acknowledge_n,
    input  wire logic              scsi_bsy,
    input  wire logic              scsi_sel,
    output logic                   scsi_bus_drive,
    output logic                   arb_start,
    output logic                   transfer_end_seen,
    output logic                   serial_hard_reset,
    output logic                   serial_sleep,
    output logic                   scsi_sleep,
    output logic                   deep_sleep,
    output logic                   scsi_needs_program,
    output logic      [DATA_W-1:0] serial_mode
);

    // strobe edges and decode
    // a write is taken once per falling edge of the write strobe,
    // so a strobe held low for many cycles writes only once
    logic wr_q;
    wire  wr_fall   = wr_q && !wr_n;
    wire  both_low  = !rd_n && !wr_n;
    wire  ser_sel   = !serial_part_select_n;
    wire  scsi_sel_h = !scsi_part_select_n;

    // resets to the idle high level so no false fall follows reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= 1'b1;
        end else begin
            wr_q <= wr_n;
        end
    end

    // serial clock watch
    // the serial clock is sampled as a plain input; a phase longer
    // than the longest legal one means the host has stopped it
    // sclk_armed masks the first compare: the pin may rest high or low
    // when reset ends, and a reset-valued sample would fake an edge
    // and open the serial registers to writes while still halted
    logic             sclk_q;
    logic             sclk_armed;
    logic [CNT_W-1:0] idle_cnt;
    logic [CNT_W-1:0] next_idle_cnt;
    wire              sclk_edge = sclk_armed && (sclk_q != serial_clk);
    wire              sclk_halted = (idle_cnt == HALT_LIMIT);

    // count up to the limit and stay there until the next edge
    assign next_idle_cnt = sclk_edge ? '0 :
                           sclk_halted ? idle_cnt : idle_cnt + CNT_W'(1);

    // starts out halted: no clock has been seen since reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q     <= 1'b0;
            sclk_armed <= 1'b0;
            idle_cnt   <= HALT_LIMIT;
        end else begin
            sclk_q     <= serial_clk;
            sclk_armed <= 1'b1;
            idle_cnt   <= next_idle_cnt;
        end
    end

    // serial hard reset
    // coincident strobes are the only pin reset of the serial part;
    // filtering to the minimum width keeps strobe overlap harmless
    logic strobe_reset_hit;

    dsc_hold_det #(
        .HOLD (HARD_RESET_CYCLES)
    ) u_hard_reset (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .cond    (both_low),
        .hit     (strobe_reset_hit)
    );

    // the software reset acts on every edge at which it stands high
    assign serial_hard_reset = strobe_reset_hit || soft_reset;

    // serial-part registers
    // no other reset touches these, so they ride through any sleep
    logic [DATA_W-1:0] ser_reg [SER_REG_NUM];
    wire  ser_write = wr_fall && ser_sel && rd_n
                      && !sclk_halted;

    // rstn is a test reset only; in use the part has no power-on reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ser_reg[0] <= SER_REG0_RST;
            ser_reg[1] <= SER_REG1_RST;
            ser_reg[2] <= SER_REG2_RST;
            ser_reg[3] <= SER_REG3_RST;
        end else if (serial_hard_reset) begin
            ser_reg[0] <= SER_REG0_RST;
            ser_reg[1] <= SER_REG1_RST;
            ser_reg[2] <= SER_REG2_RST;
            ser_reg[3] <= SER_REG3_RST;
        end else if (ser_write) begin
            ser_reg[addr] <= data_in;
        end
    end

    assign serial_mode = ser_reg[0];

    // scsi-part registers
    // writes are taken on the strobe alone, never gated by the
    // serial clock; scsi reset wipes them at the next clock edge
    logic [DATA_W-1:0] scsi_reg [SER_REG_NUM];
    wire  scsi_write = wr_fall && scsi_sel_h && rd_n
                       && scsi_reset_n;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < SER_REG_NUM; i++) begin
                scsi_reg[i] <= SCSI_REG_RST;
            end
        end else if (!scsi_reset_n) begin
            for (int i = 0; i < SER_REG_NUM; i++) begin
                scsi_reg[i] <= SCSI_REG_RST;
            end
        end else if (scsi_write) begin
            scsi_reg[addr] <= data_in;
        end
    end

    // flag left up from reset until software writes the scsi part
    // again; the set from reset wins over a clearing write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scsi_needs_program <= 1'b1;
        end else if (!scsi_reset_n) begin
            scsi_needs_program <= 1'b1;
        end else if (scsi_write) begin
            scsi_needs_program <= 1'b0;
        end
    end

    // sleep states
    // deep sleep is nothing more than both parts asleep at once
    assign serial_sleep = sclk_halted;
    assign scsi_sleep   = !scsi_reset_n;
    assign deep_sleep   = sclk_halted && !scsi_reset_n;

    // host read path
    // the bus is driven only for a selected read of an awake part;
    // a sleeping part never loads the data lines
    wire ser_rd_ok  = !rd_n && ser_sel && !sclk_halted;
    wire scsi_rd_ok = !rd_n && scsi_sel_h && scsi_reset_n;
    wire [DATA_W-1:0] rd_mux = ser_rd_ok ? ser_reg[addr] :
                               scsi_rd_ok ? scsi_reg[addr] : '0;

    // registered data; zero whenever no read is selected
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_out <= '0;
        end else begin
            data_out <= rd_mux;
        end
    end

    // one cycle behind the strobe so data is valid once enabled
    logic rd_active;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_active <= 1'b0;
        end else begin
            rd_active <= (ser_rd_ok || scsi_rd_ok) && !both_low;
        end
    end

    // the enable also drops at once when a part falls asleep in the
    // middle of a read, not one clock later
    assign data_oe = rd_active && (ser_rd_ok || scsi_rd_ok)
                     && !both_low;

    // end of transfer
    // end, write and acknowledge must stand together for the width
    logic eop_hit;
    wire  eop_cond = !transfer_end_n && !wr_n && !dma_acknowledge_n
                     && scsi_reset_n;

    dsc_hold_det #(
        .HOLD (EOP_CYCLES)
    ) u_eop (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .cond    (eop_cond),
        .hit     (eop_hit)
    );

    // registered so the pulse is one clean cycle per hold
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            transfer_end_seen <= 1'b0;
        end else begin
            transfer_end_seen <= eop_hit;
        end
    end

    // arbitration timing
    // this counter stands for the internal oscillator; it halts and
    // clears whenever the scsi reset pin is low
    dsc_arb_state_t   arb_state;
    dsc_arb_state_t   next_arb_state;
    logic [CNT_W-1:0] arb_cnt;
    logic             bsy_q;
    wire              bsy_fall = bsy_q && !scsi_bsy;
    wire              arb_en = scsi_reg[SCSI_CTRL_OFS][SCSI_ARB_EN_BIT];
    wire              arb_due = (arb_state == DSC_ARB_WAIT)
                                && (arb_cnt == ARB_LIMIT);

    // next state: idle, waiting out the delay, or owning the bus
    always_comb begin
        next_arb_state = arb_state;
        unique case (arb_state)
            DSC_ARB_IDLE: begin
                if (bsy_fall && arb_en) begin
                    next_arb_state = DSC_ARB_WAIT;
                end
            end
            DSC_ARB_WAIT: begin
                if (scsi_bsy || scsi_sel || !arb_en) begin
                    next_arb_state = DSC_ARB_IDLE;
                end else if (arb_due) begin
                    next_arb_state = DSC_ARB_OWN;
                end
            end
            DSC_ARB_OWN: begin
                // a foreign select or busy dropping frees the bus
                if (scsi_sel || bsy_fall || !arb_en) begin
                    next_arb_state = DSC_ARB_IDLE;
                end
            end
        endcase
    end

    // the reset pin clears the timer to zero and the state to idle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            arb_state <= DSC_ARB_IDLE;
            arb_cnt   <= '0;
            bsy_q     <= 1'b0;
        end else if (!scsi_reset_n) begin
            arb_state <= DSC_ARB_IDLE;
            arb_cnt   <= '0;
            bsy_q     <= scsi_bsy;
        end else begin
            arb_state <= next_arb_state;
            arb_cnt   <= (arb_state == DSC_ARB_WAIT) ?
                         arb_cnt + CNT_W'(1) : '0;
            bsy_q     <= scsi_bsy;
        end
    end

    // registered so the release lands one clock after its cause,
    // well inside both release limits
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            scsi_bus_drive <= 1'b0;
            arb_start      <= 1'b0;
        end else begin
            scsi_bus_drive <= scsi_reset_n
                              && (next_arb_state == DSC_ARB_OWN);
            arb_start      <= scsi_reset_n && arb_due
                              && !scsi_bsy && !scsi_sel && arb_en;
        end
    end

endmodule

// ==== dsc_sleep_ctrl_props.sv ====
module dsc_sleep_ctrl_props
    import dsc_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic              rd_n,
    input wire logic              wr_n,
    input wire logic              serial_part_select_n,
    input wire logic              scsi_part_select_n,
    input wire logic              soft_reset,
    input wire logic              scsi_reset_n,
    input wire logic              transfer_end_n,
    input wire logic              dma_acknowledge_n,
    input wire logic              scsi_bsy,
    input wire logic              scsi_sel,
    input wire logic              data_oe,
    input wire logic              scsi_bus_drive,
    input wire logic              arb_start,
    input wire logic              transfer_end_seen,
    input wire logic              serial_hard_reset,
    input wire logic              serial_sleep,
    input wire logic              scsi_sleep,
    input wire logic              deep_sleep,
    input wire logic              scsi_needs_program,
    input wire logic [DATA_W-1:0] serial_mode
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [CNT_W-1:0] low_cnt;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // busy-low run length; saturates so a long idle cannot wrap
    always_ff @(posedge sys_clk or negedge rstn)
        if (!rstn) low_cnt <= '0;
        else if (scsi_bsy) low_cnt <= '0;
        else if (low_cnt != '1) low_cnt <= low_cnt + CNT_W'(1);

    a_scsi_sleep_pin: assert property (scsi_sleep == !scsi_reset_n)
        else $error("scsi sleep not following reset pin");
    a_deep_sleep_both: assert property
        (deep_sleep == (serial_sleep && scsi_sleep))
        else $error("deep sleep not both parts asleep");
    a_oe_needs_read: assert property (data_oe |-> !rd_n &&
        !(serial_part_select_n && scsi_part_select_n))
        else $error("data driven without a selected read");
    a_reset_clears_own: assert property (!scsi_reset_n |=>
        !scsi_bus_drive && scsi_needs_program)
        else $error("scsi reset did not clear the part");
    a_program_until_write: assert property (scsi_needs_program &&
        (wr_n || scsi_part_select_n) |=> scsi_needs_program)
        else $error("program flag dropped without a write");
    a_arb_window: assert property (arb_start |->
        low_cnt >= ARB_START_CYCLES && low_cnt <= ARB_LATEST_CYCLES)
        else $error("arbitration outside its window");
    a_sel_release: assert property
        (scsi_bus_drive && scsi_sel |-> ##[1:6] !scsi_bus_drive)
        else $error("bus kept after select");
    a_bsy_release: assert property
        (scsi_bus_drive && $fell(scsi_bsy) |-> ##[1:11] !scsi_bus_drive)
        else $error("bus kept after busy fell");
    a_eop_qualify: assert property (transfer_end_seen |->
        $past(!transfer_end_n && !wr_n && !dma_acknowledge_n))
        else $error("end of transfer without all three");
    a_hard_reset_cause: assert property
        (serial_hard_reset && !soft_reset |-> !rd_n && !wr_n &&
        $past(!rd_n && !wr_n))
        else $error("serial hard reset without both strobes");
    a_serial_hold: assert property (serial_sleep && !soft_reset &&
        !serial_hard_reset |=> $stable(serial_mode))
        else $error("serial register changed while halted");

    c_arb: cover property (arb_start);
    c_eop: cover property (transfer_end_seen);
    c_deep: cover property (deep_sleep);
    c_hard: cover property (serial_hard_reset);
endmodule

bind dsc_sleep_ctrl dsc_sleep_ctrl_props u_props (
    .sys_clk(sys_clk), .rstn(rstn), .rd_n(rd_n), .wr_n(wr_n),
    .serial_part_select_n(serial_part_select_n),
    .scsi_part_select_n(scsi_part_select_n), .soft_reset(soft_reset),
    .scsi_reset_n(scsi_reset_n), .transfer_end_n(transfer_end_n),
    .dma_acknowledge_n(dma_acknowledge_n), .scsi_bsy(scsi_bsy),
    .scsi_sel(scsi_sel), .data_oe(data_oe),
    .scsi_bus_drive(scsi_bus_drive), .arb_start(arb_start),
    .transfer_end_seen(transfer_end_seen),
    .serial_hard_reset(serial_hard_reset), .serial_sleep(serial_sleep),
    .scsi_sleep(scsi_sleep), .deep_sleep(deep_sleep),
    .scsi_needs_program(scsi_needs_program), .serial_mode(serial_mode)
);

// ==== dsc_host_clk.sv ====
module dsc_host_clk (
    input  wire logic run,
    output logic      serial_clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // fixed grid that never meets a sys_clk edge; toggles only while
    // run, so it halts at a steady level with no short phase
    initial begin
        serial_clk = 1'b0;
        #25;
        forever begin
            #200;
            if (run) serial_clk = ~serial_clk;
        end
    end
endmodule

// ==== dsc_sleep_ctrl_tb.sv ====
module dsc_sleep_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import dsc_pkg::*;

    logic              sys_clk = 1'b0, rstn = 1'b0, run = 1'b0;
    logic              rd_n = 1'b1, wr_n = 1'b1, soft_reset = 1'b0;
    logic              serial_part_select_n = 1'b1; // parked
    logic              scsi_part_select_n = 1'b1, scsi_reset_n = 1'b1;
    logic              transfer_end_n = 1'b1, dma_acknowledge_n = 1'b1;
    logic              scsi_bsy = 1'b0, scsi_sel = 1'b0, serial_clk, oe;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] data_in = '0, data_out, serial_mode, q;
    logic              data_oe, scsi_bus_drive, arb_start;
    logic              transfer_end_seen, serial_hard_reset;
    logic              serial_sleep, scsi_sleep, deep_sleep;
    logic              scsi_needs_program;
    logic [31:0]       seed = 32'hbdc1;
    logic [DATA_W-1:0] shadow [SER_REG_NUM];
    int                bad_count = 0, samples_checked = 0, cycles = 0, n;

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    dsc_host_clk u_dsc_host_clk (.run(run), .serial_clk(serial_clk));

    dsc_sleep_ctrl u_dsc_sleep_ctrl (
        .sys_clk(sys_clk), .rstn(rstn), .serial_clk(serial_clk),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
        .serial_part_select_n(serial_part_select_n),
        .scsi_part_select_n(scsi_part_select_n), .data_out(data_out),
        .data_oe(data_oe), .soft_reset(soft_reset),
        .scsi_reset_n(scsi_reset_n), .transfer_end_n(transfer_end_n),
        .dma_acknowledge_n(dma_acknowledge_n), .scsi_bsy(scsi_bsy),
        .scsi_sel(scsi_sel), .scsi_bus_drive(scsi_bus_drive),
        .arb_start(arb_start), .transfer_end_seen(transfer_end_seen),
        .serial_hard_reset(serial_hard_reset),
        .serial_sleep(serial_sleep), .scsi_sleep(scsi_sleep),
        .deep_sleep(deep_sleep), .serial_mode(serial_mode),
        .scsi_needs_program(scsi_needs_program)
    );

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one strobed access; serial ones keep the recovery gap after
    task automatic acc(bit scsi, bit wr, logic [1:0] a, logic [7:0] d);
        @(negedge sys_clk);
        {addr, data_in} = {a, d};
        serial_part_select_n = scsi;
        scsi_part_select_n = !scsi;
        {wr_n, rd_n} = {!wr, wr};
        @(negedge sys_clk);
        {q, oe} = {data_out, data_oe};
        {wr_n, rd_n, serial_part_select_n, scsi_part_select_n} = 4'hf;
        if (!scsi) repeat (14) @(negedge sys_clk);
    endtask

    // busy falls, time the arbitration, then release by select or busy
    task automatic arb(bit by_sel);
        @(negedge sys_clk);
        scsi_bsy = 1'b1;
        @(negedge sys_clk);
        scsi_bsy = 1'b0;
        for (n = 0; arb_start !== 1'b1 && n < 30; n++) @(negedge sys_clk);
        check("arb", n*100-50 >= ARB_MIN_NS && n*100-50 <= ARB_MAX_NS, 1);
        check("bus own", scsi_bus_drive, 1'b1);
        if (by_sel) scsi_sel = 1'b1;
        else scsi_bsy = 1'b1;
        @(negedge sys_clk);
        scsi_bsy = 1'b0;
        for (n = 0; scsi_bus_drive === 1'b1 && n < 12; n++)
            @(negedge sys_clk);
        check("bus clear", n*100 + by_sel*100 <= (by_sel ?
            SEL_CLEAR_MAX_NS : BSY_CLEAR_MAX_NS), 1'b1);
        scsi_sel = 1'b0;
    endtask

    // cut a hang short; the planned run is well under this ceiling
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end

    initial begin
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        check("program flag", scsi_needs_program, 1'b1);
        run = 1'b1;
        repeat (8) @(negedge sys_clk);
        check("serial awake", serial_sleep, 1'b0);
        for (int i = 0; i < SER_REG_NUM; i++) begin
            seed = lfsr(seed);
            shadow[i] = seed[7:0];
            acc(0, 1, i[1:0], shadow[i]);
        end
        for (int i = 0; i < SER_REG_NUM; i++) begin
            acc(0, 0, i[1:0], 8'h00);
            check("serial read", q, shadow[i]);
            check("read drive", oe, 1'b1);
        end
        acc(1, 1, SCSI_CTRL_OFS, 8'h01);
        check("programmed", scsi_needs_program, 1'b0);
        arb(1);
        arb(0);
        // end of transfer with the acknowledge, then without it
        for (int k = 0; k < 2; k++) begin
            @(negedge sys_clk);
            {transfer_end_n, wr_n, dma_acknowledge_n} = {2'b00, k[0]};
            q = 8'h00;
            repeat (3) begin
                @(negedge sys_clk);
                {transfer_end_n, wr_n, dma_acknowledge_n} = 3'b111;
                q[0] = q[0] | transfer_end_seen;
            end
            check("end seen", q, {7'h0, !k[0]});
        end
        run = 1'b0;
        repeat (25) @(negedge sys_clk);
        check("serial asleep", serial_sleep, 1'b1);
        check("not deep", deep_sleep, 1'b0);
        acc(0, 1, 2'h0, ~shadow[0]);
        check("halted write", serial_mode, shadow[0]);
        seed = lfsr(seed);
        acc(1, 1, 2'h1, seed[7:0]);
        acc(1, 0, 2'h1, 8'h00);
        check("scsi read halted", q, seed[7:0]);
        // scsi reset lands in the middle of a read
        @(negedge sys_clk);
        {scsi_part_select_n, rd_n, addr} = {2'b00, 2'h1};
        @(negedge sys_clk);
        scsi_reset_n = 1'b0; // held 300 ns
        repeat (3) @(negedge sys_clk);
        check("deep sleep", deep_sleep, 1'b1);
        check("asleep drive", data_oe, 1'b0);
        check("bus off", scsi_bus_drive, 1'b0);
        check("scsi asleep", scsi_sleep, 1'b1);
        check("reprogram", scsi_needs_program, 1'b1);
        {scsi_part_select_n, rd_n, scsi_reset_n} = 3'b111;
        acc(1, 0, 2'h1, 8'h00);
        check("scsi lost", q, SCSI_REG_RST);
        run = 1'b1;
        repeat (10) @(negedge sys_clk);
        acc(0, 0, 2'h3, 8'h00);
        check("serial kept", q, shadow[3]);
        check("mode kept", serial_mode, shadow[0]);
        {rd_n, wr_n} = 2'b00; // held 200 ns
        @(negedge sys_clk);
        check("hard pulse", serial_hard_reset, 1'b1);
        @(negedge sys_clk);
        {rd_n, wr_n} = 2'b11;
        repeat (14) @(negedge sys_clk);
        check("hard reset", serial_mode, SER_REG0_RST);
        acc(0, 1, 2'h0, 8'h5a);
        check("mode write", serial_mode, 8'h5a);
        soft_reset = 1'b1;
        @(negedge sys_clk);
        soft_reset = 1'b0;
        check("soft reset", serial_mode, SER_REG0_RST);
        conclude();
    end
endmodule
